// ---- rtl/pfp_port_function_params.sv ----
// per-port function parameter registers and the conversion averager they steer
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - partner field picks companion port, paired modes
// - average the configured number of conversions
// - sample field is power-of-two exponent
// - range field selects voltage range, 000 none
module pfp_port_function_params
	import pfp_pkg::*;
#(
	parameter int NUM_PORTS = PFP_NUM_PORTS
) (
	input  wire logic                  mclk,
	input  wire logic                  resetn,
	input  wire logic                  reg_wr_en,
	input  wire logic                  reg_rd_en,
	input  wire logic [PFP_ADDR_W-1:0] reg_addr,
	input  wire logic [PFP_DATA_W-1:0] reg_wdata,
	output var  logic [PFP_DATA_W-1:0] reg_rdata,
	output var  logic                  reg_rd_valid,
	input  wire logic                  conv_start,
	input  wire logic [PFP_ADDR_W-1:0] conv_port,
	input  wire logic [PFP_MODE_W-1:0] conv_mode,
	input  wire logic                  conv_sample_valid,
	input  wire logic [PFP_DATA_W-1:0] conv_sample,
	output var  logic                  conv_busy,
	output var  logic                  avg_valid,
	output var  logic [PFP_DATA_W-1:0] avg_result,
	output var  logic                  partner_valid,
	output var  logic [PFP_ADDR_W-1:0] partner_port,
	output var  logic [2:0]            range_code,
	output var  logic                  range_fault
);
	pfp_state_e             state_reg;
	pfp_state_e             state_next;
	logic [PFP_ADDR_W-1:0]  port_reg;
	logic [PFP_MODE_W-1:0]  mode_reg;
	logic [2:0]             shift_reg;
	logic [PFP_CNT_W-1:0]   total_reg;
	logic [PFP_CNT_W-1:0]   count_reg;
	logic [PFP_ACC_W-1:0]   acc_reg;
	logic [PFP_DATA_W-1:0]  rb_data;

	wire                    start_ok   = conv_start && (32'(conv_port) < NUM_PORTS);
	// once taken, the store keeps reading the port in service, not the live request
	wire [PFP_ADDR_W-1:0]   rb_sel     = (state_reg == PFP_IDLE) ? conv_port : port_reg;
	wire [PFP_ADDR_W-1:0]   f_partner  = rb_data[PFP_PARTNER_MSB:PFP_PARTNER_LSB];
	wire [2:0]              f_samples  = rb_data[PFP_SAMPLES_MSB:PFP_SAMPLES_LSB];
	wire [2:0]              f_range    = rb_data[PFP_RANGE_MSB:PFP_RANGE_LSB];
	wire                    is_paired  = (mode_reg == PFP_MODE_PAIR_A) ||
	                                     (mode_reg == PFP_MODE_PAIR_B) ||
	                                     (mode_reg == PFP_MODE_PAIR_C);
	// a range of 000 cannot be converted, so the request is dropped
	wire                    in_fetch   = (state_reg == PFP_FETCH);
	wire                    range_bad  = in_fetch && (f_range == PFP_RANGE_NONE);
	wire                    fetch_go   = in_fetch && !range_bad;
	wire [PFP_CNT_W-1:0]    total_dec  = PFP_ONE_CNT << f_samples;
	wire                    in_run     = (state_reg == PFP_RUN);
	wire                    take       = in_run && conv_sample_valid;
	wire                    last_take  = take && ((count_reg + PFP_ONE_CNT) == total_reg);
	wire [PFP_ACC_W-1:0]    acc_sum    = acc_reg + {PFP_ACC_PAD, conv_sample};
	wire [PFP_ACC_W-1:0]    acc_shift  = acc_sum >> shift_reg;

	pfp_param_mem #(
		.DEPTH (NUM_PORTS),
		.WIDTH (PFP_DATA_W),
		.AW    (PFP_ADDR_W)
	) u_mem (
		.mclk    (mclk),
		.resetn  (resetn),
		.we      (reg_wr_en),
		.waddr   (reg_addr),
		.wdata   (reg_wdata),
		.ra_addr (reg_addr),
		.ra_data (reg_rdata),
		.rb_addr (rb_sel),
		.rb_data (rb_data)
	);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			PFP_IDLE:  state_next = start_ok ? PFP_FETCH : PFP_IDLE;
			PFP_FETCH: state_next = range_bad ? PFP_IDLE : PFP_RUN;
			PFP_RUN:   state_next = last_take ? PFP_IDLE : PFP_RUN;
			default:   state_next = PFP_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= PFP_IDLE;
			reg_rd_valid <= 1'b0;
			port_reg     <= '0;
			mode_reg     <= '0;
		end else begin
			state_reg    <= state_next;
			reg_rd_valid <= reg_rd_en;
			if (state_reg == PFP_IDLE && start_ok) begin
				port_reg <= conv_port;
				mode_reg <= conv_mode;
			end
		end
	end

	// port settings are latched once per request; later writes wait for the next one
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			partner_valid <= 1'b0;
			partner_port  <= '0;
			range_code    <= PFP_RANGE_NONE;
			shift_reg     <= '0;
			total_reg     <= PFP_ONE_CNT;
		end else if (fetch_go) begin
			partner_valid <= is_paired;
			partner_port  <= is_paired ? f_partner : '0;
			range_code    <= f_range;
			shift_reg     <= f_samples;
			total_reg     <= total_dec;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count_reg   <= '0;
			acc_reg     <= '0;
			avg_valid   <= 1'b0;
			avg_result  <= '0;
			range_fault <= 1'b0;
			conv_busy   <= 1'b0;
		end else begin
			range_fault <= range_bad;
			avg_valid   <= last_take;
			conv_busy   <= (state_next != PFP_IDLE);
			if (fetch_go || last_take) begin
				count_reg <= '0;
				acc_reg   <= '0;
			end else if (take) begin
				count_reg <= count_reg + PFP_ONE_CNT;
				acc_reg   <= acc_sum;
			end
			if (last_take) begin
				avg_result <= acc_shift[PFP_DATA_W-1:0];
			end
		end
	end

	// checks
	property p_partner_pick;
		@(posedge mclk) disable iff (!resetn)
		fetch_go && is_paired |=> partner_valid && (partner_port == $past(f_partner));
	endproperty
	a_partner_pick: assert property (p_partner_pick) else $error("partner port not taken");

	property p_partner_none;
		@(posedge mclk) disable iff (!resetn)
		fetch_go && !is_paired |=> !partner_valid;
	endproperty
	a_partner_none: assert property (p_partner_none) else $error("partner flagged unpaired");

	property p_avg_done;
		@(posedge mclk) disable iff (!resetn)
		in_run && conv_sample_valid && (count_reg == total_reg - PFP_ONE_CNT)
			|=> avg_valid && (state_reg == PFP_IDLE) ##1 !avg_valid;
	endproperty
	a_avg_done: assert property (p_avg_done) else $error("average not reported");

	property p_avg_early;
		@(posedge mclk) disable iff (!resetn)
		avg_valid |-> $past(in_run) && ($past(count_reg) == total_reg - PFP_ONE_CNT);
	endproperty
	a_avg_early: assert property (p_avg_early) else $error("average reported early");

	property p_total_pow2;
		@(posedge mclk) disable iff (!resetn)
		fetch_go |=> (total_reg == (PFP_ONE_CNT << $past(f_samples))) && (state_reg == PFP_RUN);
	endproperty
	a_total_pow2: assert property (p_total_pow2) else $error("sample count wrong");

	property p_range_take;
		@(posedge mclk) disable iff (!resetn)
		fetch_go |=> range_code == $past(f_range);
	endproperty
	a_range_take: assert property (p_range_take) else $error("range code not taken");

	property p_range_none;
		@(posedge mclk) disable iff (!resetn)
		range_bad |=> range_fault && (state_reg == PFP_IDLE) && !avg_valid;
	endproperty
	a_range_none: assert property (p_range_none) else $error("range 000 not refused");

	property p_cov_paired;
		@(posedge mclk) disable iff (!resetn)
		avg_valid && partner_valid;
	endproperty
	c_cov_paired: cover property (p_cov_paired);

	property p_cov_fault;
		@(posedge mclk) disable iff (!resetn)
		range_fault;
	endproperty
	c_cov_fault: cover property (p_cov_fault);

	property p_cov_max;
		@(posedge mclk) disable iff (!resetn)
		avg_valid && (shift_reg == 3'h7);
	endproperty
	c_cov_max: cover property (p_cov_max);
endmodule : pfp_port_function_params
`default_nettype wire

// ---- rtl/pfp_pkg.sv ----
// constants shared by the port function parameter block
package pfp_pkg;
	localparam int          PFP_NUM_PORTS    = 17;
	localparam int          PFP_DATA_W       = 12;
	localparam int          PFP_ADDR_W       = 5;
	localparam int          PFP_MODE_W       = 4;
	localparam int          PFP_ACC_W        = 19;
	localparam int          PFP_CNT_W        = 8;
	// field layout of each port_function_params word
	localparam int          PFP_PARTNER_LSB  = 0;
	localparam int          PFP_PARTNER_MSB  = 4;
	localparam int          PFP_SAMPLES_LSB  = 5;
	localparam int          PFP_SAMPLES_MSB  = 7;
	localparam int          PFP_RANGE_LSB    = 8;
	localparam int          PFP_RANGE_MSB    = 10;
	localparam logic [11:0] PFP_RESET_VALUE  = 12'h000;
	localparam logic [2:0]  PFP_RANGE_NONE   = 3'h0;
	localparam logic [2:0]  PFP_RANGE_0_10   = 3'h1;
	// modes that work with a partner port
	localparam logic [3:0]  PFP_MODE_PAIR_A  = 4'h4;
	localparam logic [3:0]  PFP_MODE_PAIR_B  = 4'h8;
	localparam logic [3:0]  PFP_MODE_PAIR_C  = 4'hB;
	localparam logic [7:0]  PFP_ONE_CNT      = 8'h01;
	localparam logic [6:0]  PFP_ACC_PAD      = 7'h00;

	typedef enum logic [2:0] {
		PFP_IDLE  = 3'b001,
		PFP_FETCH = 3'b010,
		PFP_RUN   = 3'b100
	} pfp_state_e;
endpackage : pfp_pkg

// ---- rtl/pfp_param_mem.sv ----
// parameter word store, one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module pfp_param_mem
	import pfp_pkg::*;
#(
	parameter int DEPTH  = PFP_NUM_PORTS,
	parameter int WIDTH  = PFP_DATA_W,
	parameter int AW     = PFP_ADDR_W
) (
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    ra_addr,
	output var  logic [WIDTH-1:0] ra_data,
	input  wire logic [AW-1:0]    rb_addr,
	output var  logic [WIDTH-1:0] rb_data
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	wire              ra_ok = (32'(ra_addr) < DEPTH);
	wire              rb_ok = (32'(rb_addr) < DEPTH);
	wire              w_ok  = we && (32'(waddr) < DEPTH);

	// writes past the last port are dropped, reads there give zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= WIDTH'(PFP_RESET_VALUE);
			end
			ra_data <= '0;
			rb_data <= '0;
		end else begin
			if (w_ok) begin
				mem_reg[waddr] <= wdata;
			end
			ra_data <= ra_ok ? mem_reg[ra_addr] : '0;
			rb_data <= rb_ok ? mem_reg[rb_addr] : '0;
		end
	end
endmodule : pfp_param_mem
`default_nettype wire

// ---- testbench/pfp_port_function_params_tb_top.sv ----
// self-checking bench for the port function parameter block
`timescale 1ns/1ps
`default_nettype none
module pfp_port_function_params_tb_top;
	import pfp_pkg::*;
	logic                  mclk, resetn, reg_wr_en, reg_rd_en, conv_start, conv_sample_valid;
	logic [PFP_ADDR_W-1:0] reg_addr, conv_port, partner_port;
	logic [PFP_DATA_W-1:0] reg_wdata, reg_rdata, conv_sample, avg_result;
	logic [PFP_MODE_W-1:0] conv_mode;
	logic                  reg_rd_valid, conv_busy, avg_valid, partner_valid, range_fault;
	logic [2:0]            range_code;
	logic [31:0]           lfsr_q = 32'hE6BF7AFA;
	logic [11:0]           shadow[17];
	logic [3:0]            modes[8] = '{4'h4, 4'h8, 4'hB, 4'h1, 4'h7, 4'h3, 4'h4, 4'hB};
	logic [11:0]           rd_q[$];
	logic [20:0]           cv_q[$];
	logic                  flt_q[$];
	int                    miscompares = 0;
	int                    n_tests = 0;
	logic [11:0]           cfg_word;
	wire  [20:0]           conv_got = {partner_valid, partner_port, range_code, avg_result};

	pfp_port_function_params #(.NUM_PORTS(17)) dut (
		.mclk(mclk), .resetn(resetn), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rd_valid(reg_rd_valid), .conv_start(conv_start), .conv_port(conv_port),
		.conv_mode(conv_mode), .conv_sample_valid(conv_sample_valid),
		.conv_sample(conv_sample), .conv_busy(conv_busy), .avg_valid(avg_valid),
		.avg_result(avg_result), .partner_valid(partner_valid), .partner_port(partner_port),
		.range_code(range_code), .range_fault(range_fault));

	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step

	task automatic chk_reg(input logic [11:0] got, input logic [11:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: reg got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic chk_conv(input logic [20:0] got, input logic [20:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: conv got %h expected %h", $time, got, exp);
		end
	endtask : chk_conv

	task automatic chk_busy(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: busy got %h expected %h", $time, got, exp);
		end
	endtask : chk_busy

	// a result with no note behind it is always a mismatch
	task automatic chk_none(input logic [20:0] got);
		n_tests++;
		miscompares++;
		$display("Error at %0t: unexpected result got %h expected none", $time, got);
	endtask : chk_none

	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic wr(input logic [4:0] a, input logic [11:0] d);
		@(posedge mclk);
		reg_wr_en <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr_en <= 1'b0;
	endtask : wr

	task automatic rd(input logic [4:0] a, input logic [11:0] e);
		@(posedge mclk);
		reg_rd_en <= 1'b1;
		reg_addr  <= a;
		rd_q.push_back(e);
		@(posedge mclk);
		reg_rd_en <= 1'b0;
	endtask : rd

	// settings are latched at fetch, so the word is written before the start
	task automatic conv(input logic [4:0] p, input logic [3:0] m, input logic [11:0] w);
		logic [18:0] sum;
		logic        pr;
		sum = '0;
		pr = (m == PFP_MODE_PAIR_A) || (m == PFP_MODE_PAIR_B) || (m == PFP_MODE_PAIR_C);
		wr(p, w);
		@(posedge mclk);
		conv_start <= 1'b1;
		conv_port  <= p;
		conv_mode  <= m;
		@(posedge mclk);
		conv_start <= 1'b0;
		if (w[10:8] == PFP_RANGE_NONE) begin
			flt_q.push_back(1'b1);
		end else begin
			for (int k = 0; k < (1 << w[7:5]); k++) begin
				@(posedge mclk);
				lfsr_q = lfsr_step(lfsr_q);
				conv_sample_valid <= 1'b1;
				conv_sample       <= lfsr_q[11:0];
				// a start while running must be ignored
				conv_start        <= (k == 0);
				sum += 19'(lfsr_q[11:0]);
			end
			cv_q.push_back({pr, pr ? w[4:0] : 5'h00, w[10:8], 12'(sum >> w[7:5])});
		end
		@(posedge mclk);
		conv_sample_valid <= 1'b0;
		conv_start        <= 1'b0;
		for (int k = 0; k < 20 && conv_busy !== 1'b0; k++) @(posedge mclk);
		@(posedge mclk);
	endtask : conv

	// registered outputs sampled at the edge, so no race with the design
	always @(posedge mclk) begin
		if (reg_rd_valid === 1'b1) begin
			if (rd_q.size() != 0) chk_reg(reg_rdata, rd_q.pop_front());
			else chk_none(21'(reg_rdata));
		end
		if (avg_valid === 1'b1) begin
			if (cv_q.size() != 0) chk_conv(conv_got, cv_q.pop_front());
			else chk_none(conv_got);
			chk_busy(conv_busy, 1'b0);
		end
		if (range_fault === 1'b1) begin
			if (flt_q.size() != 0) chk_conv(21'({avg_valid, range_fault}), 21'(flt_q.pop_front()));
			else chk_none(21'h1);
			chk_busy(conv_busy, 1'b0);
		end
		if (conv_sample_valid === 1'b1) chk_busy(conv_busy, 1'b1);
	end

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (4000) @(posedge mclk);
		miscompares++;
		stop_test;
	end

	initial begin
		resetn = 1'b0;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		conv_start = 1'b0;
		conv_port = '0;
		conv_mode = '0;
		conv_sample_valid = 1'b0;
		conv_sample = '0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		for (int i = 0; i < 17; i++) rd(5'(i), PFP_RESET_VALUE);
		for (int i = 0; i < 17; i++) begin
			lfsr_q = lfsr_step(lfsr_q);
			shadow[i] = lfsr_q[11:0];
			wr(5'(i), shadow[i]);
		end
		// unmapped index must neither store nor alias a real port
		wr(5'd17, 12'hFFF);
		for (int i = 0; i < 19; i++) rd(5'(i), i < 17 ? shadow[i] : 12'h000);
		for (int n = 0; n < 8; n++) begin
			lfsr_q = lfsr_step(lfsr_q);
			cfg_word = {lfsr_q[11], PFP_RANGE_0_10, 3'(n), lfsr_q[4:0]};
			conv(5'(lfsr_q % 17), modes[n], cfg_word);
		end
		conv(5'd2, 4'h1, 12'h0E5);
		// a start naming a port past the last one is dropped with no sign
		@(posedge mclk);
		conv_start <= 1'b1;
		conv_port  <= 5'd20;
		@(posedge mclk);
		conv_start <= 1'b0;
		repeat (6) @(posedge mclk);
		if (rd_q.size() + cv_q.size() + flt_q.size() != 0) miscompares++;
		stop_test;
	end
endmodule : pfp_port_function_params_tb_top
`default_nettype wire
